// >>> hdl/coe_bank.sv
// Two-wire slave register bank gating six differential clock output pairs
`timescale 1ns/10ps
module coe_bank #(
    parameter int NUM_PAIRS = 6
) (
    input  wire logic                 clock,
    input  wire logic                 srst,
    input  wire logic                 scl_in,
    input  wire logic                 sda_in,
    output logic                      sda_out,
    output logic                      sda_oe_n,
    input  wire logic                 ref_clk_in,
    output logic [NUM_PAIRS-1:0]      clock_pair_t,
    output logic [NUM_PAIRS-1:0]      clock_pair_c
);

    coe_pkg::coe_state_e  st_reg;
    logic [7:0]           shift_reg;
    logic [3:0]           bit_reg;
    logic [3:0]           idx_reg;
    logic                 addr_phase_reg;
    logic                 rw_reg;
    logic                 sda_oe_n_reg;
    logic                 scl_q;
    logic                 sda_q;
    logic [5:0]           en_reg;
    logic [5:0]           gate_reg;
    logic [5:0]           t_reg;
    logic                 scl_rise;
    logic                 scl_fall;
    logic                 start_cond;
    logic                 stop_cond;
    logic                 byte_done;
    logic                 addr_match;
    logic                 wr_strobe;
    logic [3:0]           wr_ofs;
    logic [3:0]           idx_inc;
    logic [7:0]           next_tx;

    // Readback value of one register byte at the given offset
    function automatic logic [7:0] coe_byte(input logic [3:0] ofs, input logic [5:0] en);
        logic [7:0] v;
        v = coe_pkg::RSVD_VALUE;
        if (ofs <= coe_pkg::OFS_BYTE_LAST)
            v = coe_pkg::RSVD_VALUE;
        else if (ofs == coe_pkg::OFS_LOW_PAIRS)
        begin
            v = coe_pkg::LOW_RSVD;
            v[coe_pkg::POS_PAIR0] = en[0];
            v[coe_pkg::POS_PAIR1] = en[1];
            v[coe_pkg::POS_PAIR2] = en[2];
            v[coe_pkg::POS_PAIR3] = en[3];
        end
        else if (ofs == coe_pkg::OFS_HIGH_PAIRS)
        begin
            v = coe_pkg::HIGH_RSVD;
            v[coe_pkg::POS_PAIR4] = en[4];
            v[coe_pkg::POS_PAIR5] = en[5];
        end
        return v;
    endfunction : coe_byte

    assign scl_rise   = scl_in & ~scl_q;
    assign scl_fall   = ~scl_in & scl_q;
    assign start_cond = scl_in & scl_q & sda_q & ~sda_in;
    assign stop_cond  = scl_in & scl_q & ~sda_q & sda_in;
    assign byte_done  = (st_reg == coe_pkg::ST_RX) && scl_fall && (bit_reg == coe_pkg::BITS_PER_BYTE);
    assign addr_match = (shift_reg[7:1] == coe_pkg::ADDR_WRITE[7:1]);
    assign wr_strobe  = byte_done && !addr_phase_reg && (idx_reg >= coe_pkg::HDR_BYTES);
    assign wr_ofs     = idx_reg - coe_pkg::HDR_BYTES;
    assign idx_inc    = (idx_reg == coe_pkg::IDX_MAX) ? idx_reg : idx_reg + 4'h1;
    // Read index 0 is the count byte, index n is register n-1
    assign next_tx    = coe_byte(idx_reg - 4'h1, en_reg);

    assign sda_out  = 1'b0;
    assign sda_oe_n = sda_oe_n_reg;

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end
        else
        begin
            scl_q <= scl_in;
            sda_q <= sda_in;
        end
    end

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            st_reg         <= coe_pkg::ST_IDLE;
            shift_reg      <= 8'h00;
            bit_reg        <= 4'h0;
            idx_reg        <= 4'h0;
            addr_phase_reg <= 1'b0;
            rw_reg         <= 1'b0;
            sda_oe_n_reg   <= 1'b1;
        end
        else if (start_cond)
        begin
            st_reg         <= coe_pkg::ST_RX;
            bit_reg        <= 4'h0;
            idx_reg        <= 4'h0;
            addr_phase_reg <= 1'b1;
            sda_oe_n_reg   <= 1'b1;
        end
        else if (stop_cond)
        begin
            st_reg       <= coe_pkg::ST_IDLE;
            sda_oe_n_reg <= 1'b1;
        end
        else
        begin
            case (st_reg)
                coe_pkg::ST_RX:
                begin
                    if (scl_rise && bit_reg != coe_pkg::BITS_PER_BYTE)
                    begin
                        shift_reg <= {shift_reg[6:0], sda_in};
                        bit_reg   <= bit_reg + 4'h1;
                    end
                    else if (byte_done)
                    begin
                        if (addr_phase_reg && !addr_match)
                            st_reg <= coe_pkg::ST_IDLE;
                        else
                        begin
                            st_reg       <= coe_pkg::ST_RX_ACK;
                            sda_oe_n_reg <= 1'b0;
                            if (addr_phase_reg)
                                rw_reg <= shift_reg[0];
                        end
                    end
                end
                coe_pkg::ST_RX_ACK:
                begin
                    // The acknowledge is held through the whole ninth clock, high phase too
                    if (scl_fall)
                    begin
                        bit_reg <= 4'h0;
                        if (addr_phase_reg && rw_reg)
                        begin
                            st_reg       <= coe_pkg::ST_TX;
                            shift_reg    <= coe_pkg::BYTE_COUNT;
                            sda_oe_n_reg <= coe_pkg::BYTE_COUNT[7];
                            idx_reg      <= 4'h1;
                        end
                        else
                        begin
                            st_reg       <= coe_pkg::ST_RX;
                            sda_oe_n_reg <= 1'b1;
                            if (!addr_phase_reg)
                                idx_reg <= idx_inc;
                        end
                        addr_phase_reg <= 1'b0;
                    end
                end
                coe_pkg::ST_TX:
                begin
                    if (scl_fall)
                    begin
                        if (bit_reg == coe_pkg::LAST_TX_BIT)
                        begin
                            st_reg       <= coe_pkg::ST_TX_ACK;
                            sda_oe_n_reg <= 1'b1;
                        end
                        else
                        begin
                            bit_reg      <= bit_reg + 4'h1;
                            shift_reg    <= {shift_reg[6:0], 1'b1};
                            sda_oe_n_reg <= shift_reg[6];
                        end
                    end
                end
                coe_pkg::ST_TX_ACK:
                begin
                    // A host not-acknowledge ends the read; the bus stays released
                    if (scl_rise && sda_in)
                        st_reg <= coe_pkg::ST_IDLE;
                    else if (scl_fall)
                    begin
                        st_reg       <= coe_pkg::ST_TX;
                        bit_reg      <= 4'h0;
                        shift_reg    <= next_tx;
                        sda_oe_n_reg <= next_tx[7];
                        idx_reg      <= idx_inc;
                    end
                end
                default:
                begin
                    sda_oe_n_reg <= 1'b1;
                end
            endcase
        end
    end

    // Bytes past the last register and reserved bits are acknowledged but not stored
    always_ff @(posedge clock)
    begin
        if (srst)
            en_reg <= coe_pkg::EN_RESET;
        else if (wr_strobe && wr_ofs == coe_pkg::OFS_LOW_PAIRS)
        begin
            en_reg[0] <= shift_reg[coe_pkg::POS_PAIR0];
            en_reg[1] <= shift_reg[coe_pkg::POS_PAIR1];
            en_reg[2] <= shift_reg[coe_pkg::POS_PAIR2];
            en_reg[3] <= shift_reg[coe_pkg::POS_PAIR3];
        end
        else if (wr_strobe && wr_ofs == coe_pkg::OFS_HIGH_PAIRS)
        begin
            en_reg[4] <= shift_reg[coe_pkg::POS_PAIR4];
            en_reg[5] <= shift_reg[coe_pkg::POS_PAIR5];
        end
    end

    // Gates move only while the reference is low, so no output pulse is ever cut short
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            gate_reg <= coe_pkg::EN_RESET;
            t_reg    <= 6'h00;
        end
        else
        begin
            if (!ref_clk_in)
                gate_reg <= en_reg;
            t_reg <= {6{ref_clk_in}} & gate_reg;
        end
    end

    assign clock_pair_t = t_reg[NUM_PAIRS-1:0];
    assign clock_pair_c = ~t_reg[NUM_PAIRS-1:0];

    // Checks other than AST_EN_POWER_UP stay off during reset, where the bus history is undefined
    AST_EN_POWER_UP: assert property (@(posedge clock) srst |=> en_reg == coe_pkg::EN_RESET)
        else $error("enables not all one after reset");
    AST_RSVD_BYTES: assert property (@(posedge clock) disable iff (srst)
        (st_reg == coe_pkg::ST_TX && idx_reg >= 4'h2 && idx_reg <= 4'h6) |-> sda_oe_n_reg)
        else $error("reserved byte drove a zero");
    AST_LOW_RSVD: assert property (@(posedge clock) disable iff (srst)
        (coe_byte(coe_pkg::OFS_LOW_PAIRS, en_reg) & coe_pkg::LOW_RSVD) == coe_pkg::LOW_RSVD)
        else $error("byte 5 reserved bits not one");
    AST_HIGH_RSVD: assert property (@(posedge clock) disable iff (srst)
        (coe_byte(coe_pkg::OFS_HIGH_PAIRS, en_reg) & 8'hf5) == coe_pkg::HIGH_RSVD)
        else $error("byte 6 reserved bits wrong");
    AST_WRITE_LOW: assert property (@(posedge clock) disable iff (srst)
        (wr_strobe && wr_ofs == coe_pkg::OFS_LOW_PAIRS)
        |=> en_reg[3:0] == {$past(shift_reg[2]), $past(shift_reg[3]),
                            $past(shift_reg[6]), $past(shift_reg[7])})
        else $error("byte 5 write not applied");
    AST_WRITE_HIGH: assert property (@(posedge clock) disable iff (srst)
        (wr_strobe && wr_ofs == coe_pkg::OFS_HIGH_PAIRS)
        |=> en_reg[5:4] == {$past(shift_reg[1]), $past(shift_reg[3])})
        else $error("byte 6 write not applied");
    AST_ADDR_ACK: assert property (@(posedge clock) disable iff (srst)
        (byte_done && addr_phase_reg && !start_cond && !stop_cond)
        |=> (!sda_oe_n_reg == $past(addr_match)))
        else $error("address acknowledge wrong");
    AST_STOP_IDLE: assert property (@(posedge clock) disable iff (srst)
        (stop_cond && !start_cond) |=> st_reg == coe_pkg::ST_IDLE && sda_oe_n_reg)
        else $error("stop did not release the bus");
    AST_COUNT_FIRST: assert property (@(posedge clock) disable iff (srst)
        (st_reg == coe_pkg::ST_RX_ACK && addr_phase_reg && rw_reg && scl_fall
         && !start_cond && !stop_cond) |=> shift_reg == coe_pkg::BYTE_COUNT)
        else $error("read did not start with the count");
    AST_GATE_LOW_ONLY: assert property (@(posedge clock) disable iff (srst)
        (gate_reg != $past(gate_reg)) |-> !$past(ref_clk_in))
        else $error("gate changed while reference high");
    AST_STATIC_OFF: assert property (@(posedge clock) disable iff (srst)
        (!gate_reg[0]) |=> !t_reg[0] && clock_pair_c[0])
        else $error("disabled pair still toggling");
    AST_GATE_TRACKS: assert property (@(posedge clock) disable iff (srst)
        (!ref_clk_in) |=> gate_reg == $past(en_reg))
        else $error("gate did not follow enables in low phase");

    // Open drain: the slave pulls the line only in its own acknowledge and data slots
    AST_RX_ACK_DRIVE: assert property (@(posedge clock) disable iff (srst)
        (st_reg == coe_pkg::ST_RX_ACK) |-> !sda_oe_n_reg)
        else $error("acknowledge slot not driven");
    AST_IDLE_QUIET: assert property (@(posedge clock) disable iff (srst)
        (st_reg == coe_pkg::ST_IDLE) |-> sda_oe_n_reg)
        else $error("idle slave pulls the line");
    AST_TX_ACK_RELEASE: assert property (@(posedge clock) disable iff (srst)
        (st_reg == coe_pkg::ST_TX_ACK) |-> sda_oe_n_reg)
        else $error("line held in host acknowledge slot");
    AST_TX_HOLD: assert property (@(posedge clock) disable iff (srst)
        (st_reg == coe_pkg::ST_TX && scl_in && scl_q) |-> $stable(sda_oe_n_reg))
        else $error("read data moved while clock high");
    AST_EXTRA_IGNORED: assert property (@(posedge clock) disable iff (srst)
        (wr_strobe && wr_ofs > coe_pkg::OFS_HIGH_PAIRS) |=> $stable(en_reg))
        else $error("byte past the last register was stored");

    COV_WRITE_LOW: cover property (@(posedge clock) wr_strobe && wr_ofs == coe_pkg::OFS_LOW_PAIRS);
    COV_READ_COUNT: cover property (@(posedge clock) st_reg == coe_pkg::ST_TX && idx_reg == 4'h1);
    COV_READ_LAST: cover property (@(posedge clock) st_reg == coe_pkg::ST_TX && idx_reg == 4'h8);
    COV_PAIR_OFF: cover property (@(posedge clock) gate_reg[0] ##1 !gate_reg[0]);
    COV_FOREIGN_ADDR: cover property (@(posedge clock) byte_done && addr_phase_reg && !addr_match);

endmodule : coe_bank

// >>> inc/coe_pkg.sv
// Constants for the clock output enable bank and its two-wire slave
// Summary of operation
// - Bytes 0 to 4 are reserved and read as all ones after power-up.
// - Byte 5 bit 7 enables clock pair zero; power-up value one.
// - Byte 5 bit 6 enables clock pair one; power-up value one.
// - Byte 5 bit 3 enables clock pair two; power-up value one.
// - Byte 5 bit 2 enables clock pair three; power-up value one.
// - Byte 6 bit 3 enables clock pair four; power-up value one.
// - Byte 6 bit 1 enables clock pair five; power-up value one.
// - Byte 5 bits 5, 4, 1 and 0 are reserved and read as one.
// - Byte 6 bits 7 to 5 read zero; bits 4, 2, 0 read one.
// - Write address d4 is acknowledged, then command, count, data bytes, each acknowledged.
// - Data bytes load in ascending order from byte 0 until stop arrives.
// - Read address d5 returns a count byte, then bytes 0 to 6 in order.
package coe_pkg;
    localparam logic [7:0] ADDR_WRITE    = 8'hd4;
    localparam logic [7:0] ADDR_READ     = 8'hd5;
    localparam logic [7:0] BYTE_COUNT    = 8'h07;
    localparam logic [3:0] OFS_BYTE_LAST = 4'h4;
    localparam logic [3:0] OFS_LOW_PAIRS = 4'h5;
    localparam logic [3:0] OFS_HIGH_PAIRS = 4'h6;
    localparam logic [3:0] HDR_BYTES     = 4'h2;
    localparam logic [3:0] IDX_MAX       = 4'hf;
    localparam logic [7:0] RSVD_VALUE    = 8'hff;
    localparam logic [7:0] LOW_RSVD      = 8'h33;
    localparam logic [7:0] HIGH_RSVD     = 8'h15;
    localparam logic [5:0] EN_RESET      = 6'h3f;
    localparam int         POS_PAIR0     = 7;
    localparam int         POS_PAIR1     = 6;
    localparam int         POS_PAIR2     = 3;
    localparam int         POS_PAIR3     = 2;
    localparam int         POS_PAIR4     = 3;
    localparam int         POS_PAIR5     = 1;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] LAST_TX_BIT   = 4'h7;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RX,
        ST_RX_ACK,
        ST_TX,
        ST_TX_ACK
    } coe_state_e;
endpackage : coe_pkg

// >>> tb/coe_host.sv
// Two-wire host controller model facing the clock output enable bank
`timescale 1ns/10ps
module coe_host (
    input  wire logic clock,
    input  wire logic sda_wire,
    output logic      scl,
    output logic      sda_drv
);
    initial {scl, sda_drv} = 2'b11;
    // Lines move on falling edges only, half a cycle away from sampling
    task automatic lines(input logic s, input logic c, input int n);
        sda_drv = s;
        scl     = c;
        repeat (n) @(negedge clock);
    endtask : lines
    task automatic bit_io(input logic b, output logic r);
        lines(b, 1'b0, 3);
        lines(b, 1'b1, 2);
        r = sda_wire;
        lines(b, 1'b1, 2);
        lines(b, 1'b0, 2);
    endtask : bit_io
    task automatic start_cond();
        lines(1'b0, 1'b1, 3);
        lines(1'b0, 1'b0, 2);
    endtask : start_cond
    task automatic stop_cond();
        lines(1'b0, 1'b0, 3);
        lines(1'b0, 1'b1, 3);
        lines(1'b1, 1'b1, 3);
    endtask : stop_cond
    // MSB first; the ninth bit sends ack_in and folds a high wire into nack
    task automatic xfer(input logic [7:0] d, input logic ack_in,
                        output logic [7:0] q, inout logic nack);
        logic a;
        for (int i = 7; i >= 0; i--)
            bit_io(d[i], q[i]);
        bit_io(ack_in, a);
        nack = nack | a;
    endtask : xfer
    // Data byte k sits at bits 63-8k down; command and count are ignored
    task automatic write_block(input logic [7:0] addr, input int n,
                               input logic [63:0] d, output logic nack);
        logic [7:0] q;
        nack = 1'b0;
        start_cond();
        xfer(addr, 1'b1, q, nack);
        xfer(8'h00, 1'b1, q, nack);
        xfer(8'h07, 1'b1, q, nack);
        for (int k = 0; k < n; k++)
            xfer(d[63-8*k -: 8], 1'b1, q, nack);
        stop_cond();
    endtask : write_block
    // Count, then bytes 0 to 6, land from the top; the host acks each one
    task automatic read_block(output logic [63:0] r, output logic nack);
        logic [7:0] q;
        nack = 1'b0;
        start_cond();
        xfer(coe_pkg::ADDR_READ, 1'b1, q, nack);
        for (int k = 0; k < 8; k++)
            xfer(8'hff, 1'b0, r[63-8*k -: 8], nack);
        stop_cond();
    endtask : read_block
endmodule : coe_host

// >>> tb/test_clock_output_enable_bank.sv
// Self-checking bench for the clock output enable bank
`timescale 1ns/10ps
module test_clock_output_enable_bank;
    logic       clock, srst, ref_clk_in, scl, host_sda, sda_out, sda_oe_n;
    wire        sda_wire;
    logic [5:0] clock_pair_t, clock_pair_c;
    int         error_cnt, cmp_count;
    // Pulled-up open-drain wire: low while any party pulls it
    assign sda_wire = host_sda & (sda_oe_n | sda_out);
    coe_bank #(.NUM_PAIRS(6)) u_coe_bank (.clock(clock), .srst(srst), .scl_in(scl),
        .sda_in(sda_wire), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .ref_clk_in(ref_clk_in),
        .clock_pair_t(clock_pair_t), .clock_pair_c(clock_pair_c));
    coe_host u_coe_host (.clock(clock), .sda_wire(sda_wire), .scl(scl), .sda_drv(host_sda));
    initial
        forever #5 clock = ~clock;
    always #40 ref_clk_in = ~ref_clk_in;
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp, input string what);
        cmp_count++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("Error at %0t: %s is %h, expected %h", $time, what, seen, exp);
        end
    endtask : chk
    task automatic final_report();
        $display("Checks %0d, mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : final_report
    // Write n data bytes, read everything back, then watch the pair outputs
    task automatic wr_rd(input logic good, input int n, input logic [15:0] w,
                         input logic [15:0] e, input logic [5:0] en_exp, input string name);
        logic [63:0] r;
        logic [5:0]  hi;
        logic [5:0]  lo;
        logic        nack;
        logic        comp;
        u_coe_host.write_block(good ? coe_pkg::ADDR_WRITE : 8'ha0, n, {40'h0, w, 8'h0}, nack);
        chk({63'h0, nack}, {63'h0, ~good}, "write nack");
        u_coe_host.read_block(r, nack);
        chk({63'h0, nack}, 64'h0, "read nack");
        chk(r, {8'h07, 40'hff_ffff_ffff, e}, "readback");
        hi   = 6'h00;
        lo   = 6'h3f;
        comp = 1'b1;
        repeat (24)
        begin
            @(negedge clock);
            hi   = hi | clock_pair_t;
            lo   = lo & clock_pair_t;
            comp = comp & (clock_pair_c === ~clock_pair_t);
        end
        chk({58'h0, hi}, {58'h0, en_exp}, "toggling pairs");
        chk({58'h0, lo}, 64'h0, "pairs never low");
        chk({63'h0, comp}, 64'h1, "complement legs");
        $display("Test %s done", name);
    endtask : wr_rd
    task automatic t_power_up();
        srst = 1'b1;
        repeat (12) @(negedge clock);
        srst = 1'b0;
        @(negedge clock);
        wr_rd(1'b1, 0, 16'h0000, 16'hff1f, 6'h3f, "defaults");
    endtask : t_power_up
    task automatic t_all_off();
        wr_rd(1'b1, 7, 16'h0000, 16'h3315, 6'h00, "all off");
    endtask : t_all_off
    task automatic t_early_stop();
        wr_rd(1'b1, 6, 16'h84ff, 16'hb715, 6'h09, "early stop");
    endtask : t_early_stop
    // Reserved bits written as the inverse of their defaults, plus a byte past the end
    task automatic t_reserved();
        wr_rd(1'b1, 8, 16'h48ea, 16'h7b1f, 6'h36, "reserved and extra");
    endtask : t_reserved
    task automatic t_foreign_addr();
        wr_rd(1'b0, 7, 16'h0000, 16'h7b1f, 6'h36, "foreign address");
    endtask : t_foreign_addr
    initial
    begin
        {clock, srst, ref_clk_in} = 3'b010;
        error_cnt = 0;
        cmp_count = 0;
        t_power_up();
        t_all_off();
        t_early_stop();
        t_reserved();
        t_foreign_addr();
        t_power_up();
        final_report();
    end
    // A hang counts as a mismatch and still reaches the verdict
    initial
    begin
        repeat (100000) @(posedge clock);
        error_cnt++;
        $display("Error at %0t: run did not finish", $time);
        final_report();
    end
endmodule : test_clock_output_enable_bank
